// >>> dv/touch_adc_conversion_control_bench.sv
// Self-checking bench for the touch converter control block
module touch_adc_conversion_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pen_down = 1'b0, err;
    logic [11:0] paddr = 12'h000, base = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic [1:0]  res, ck;
    logic [3:0]  cd;
    logic [3:0]  singles [9] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hb, 4'hc};
    logic [3:0]  drv [4] = '{4'hd, 4'hf, 4'he, 4'h0};
    wire logic   pready, pslverr, xon, yon, act, pwr, strb;
    wire logic [31:0] prdata;
    wire logic [3:0]  chan;
    wire logic [11:0] smp;
    int fails = 0, n_tests = 0, seed = 62860, cyc = 0, nstrb = 0, m, e, k, r, n;

    touch_conv_ctrl i_dut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pen_down(pen_down), .adc_sample(smp), .x_drivers_on(xon),
        .y_drivers_on(yon), .conv_active(act), .conv_channel(chan),
        .converter_powered(pwr), .result_strobe(strb));
    touch_panel_model i_panel (.clock(clock), .conv_active(act), .conv_channel(chan),
        .converter_powered(pwr), .base(base), .adc_sample(smp));

    always #10 clock = ~clock;
    // Longest run is well under this ceiling
    always @(posedge clock) begin
        cyc++;
        nstrb += int'(strb === 1'b1);
        if (cyc == 80000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
        n_tests++;
        if (got < lo || got > hi) begin
            fails++;
            $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask
    // Entered just after a rising edge; waits for pready, only the timeout ends a hang
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        penable <= 1'b0;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    function automatic logic [31:0] ctl(logic pen, logic halt, logic [3:0] sel,
                                        logic [1:0] rs, logic [1:0] avg, logic [1:0] c,
                                        logic filt);
        return {16'h0000, pen, halt, sel, rs, avg, c, 3'h0, filt};
    endfunction
    function automatic logic [8:0] chans(logic [3:0] c);
        case (c)
            4'h1: return 9'h003;
            4'h2: return 9'h00f;
            4'h3: return 9'h001;
            4'h4: return 9'h002;
            4'h5: return 9'h00c;
            4'h6: return 9'h010;
            4'h7: return 9'h020;
            4'h8, 4'h9: return 9'h040;
            4'ha: return 9'h080;
            4'hb: return 9'h070;
            4'hc: return 9'h100;
            default: return 9'h000;
        endcase
    endfunction
    function automatic int conv(logic [1:0] rs, logic [1:0] c);
        int b;
        b = (rs == 2'h1) ? 8 : (rs == 2'h2) ? 10 : 12;
        return (b + 4) * ((50 * (1 << c) + 7) / 8);
    endfunction
    function automatic int nsamp(logic [1:0] avg, logic filt);
        if (avg == 2'h0)
            return 1;
        return filt ? ((avg == 2'h1) ? 5 : (avg == 2'h2) ? 9 : 15) : (4 << (avg - 1));
    endfunction
    task automatic run_wait(input int cap);
        k = 0;
        while (act !== 1'b1 && k < 8) begin
            @(posedge clock);
            k++;
        end
        m = 0;
        while (act === 1'b1 && m < cap) begin
            @(posedge clock);
            m++;
        end
    endtask
    task automatic chk_res(input logic [8:0] mask);
        for (int ch = 0; ch < 9; ch++) begin
            if (mask[ch]) begin
                apb(1'b0, 12'h010 + 12'(4 * ch), 32'h0);
                chk("result word", {20'h0, base ^ {3{4'(ch)}}}, rd);
            end
        end
    endtask
    task automatic wait_strobes(input int want);
        k = 0;
        while (nstrb < want && k < 20000) begin
            @(posedge clock);
            k++;
        end
    endtask

    initial begin
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl after reset", 32'h00004000, rd);
        chk("powered after reset", 32'h1, 32'(pwr));
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped error", 32'h1, 32'(err));
        apb(1'b1, 12'h010, 32'hffffffff);
        apb(1'b0, 12'h010, 32'h0);
        chk("result read only", 32'h0, rd);
        // One-shot codes; each average and filter setting at least once
        for (int i = 0; i < 9; i++) begin
            r = $random(seed);
            res = r[1:0];
            // fast conversion clocks only with short resolutions
            ck = (res == 2'h1) ? {1'b0, r[2]} : (res == 2'h2) ? 2'h1 + 2'(r[2]) : 2'h2;
            base = 12'($random(seed));
            cd = singles[i];
            n = $countones(chans(cd));
            apb(1'b1, 12'h000, ctl(1'b0, 1'b0, cd, res, 2'(i), ck, i[2]));
            run_wait(20000);
            e = n * nsamp(2'(i), i[2]) * conv(res, ck);
            chk_rng("busy time", e, e + 3 * n * (nsamp(2'(i), i[2]) + 1) + 4, m);
            // Scaling of short results is left open, so only full width is compared
            if (res == 2'h0 || res == 2'h3)
                chk_res(chans(cd));
            apb(1'b0, 12'h000, 32'h0);
            chk("ctrl readback", ctl(1'b0, 1'b1, 4'h0, res, 2'(i), ck, i[2]), rd & 32'hfff1);
        end
        foreach (drv[j]) begin
            apb(1'b1, 12'h000, ctl(1'b0, 1'b0, drv[j], 2'h0, 2'h0, 2'h2, 1'b0));
            repeat (2) @(posedge clock);
            chk("x drivers", 32'(drv[j] == 4'hd), 32'(xon));
            chk("y drivers", 32'(drv[j] == 4'hf), 32'(yon));
            chk("no conversion", 32'h0, 32'(act));
        end
        pen_down <= 1'b1;
        repeat (4) @(posedge clock);
        apb(1'b0, 12'h000, 32'h0);
        chk("pen read", 32'h1, 32'(rd[15]));
        pen_down <= 1'b0;
        base = 12'($random(seed));
        repeat (4) @(posedge clock);
        nstrb = 0;
        apb(1'b1, 12'h000, ctl(1'b1, 1'b0, 4'h3, 2'h0, 2'h0, 2'h2, 1'b0));
        repeat (300) @(posedge clock);
        chk_rng("waits for pen", 0, 0, nstrb);
        pen_down <= 1'b1;
        wait_strobes(1);
        run_wait(5000);
        chk_res(9'h001);
        // Repeating panel scans end when the pen lifts
        for (int s = 1; s < 3; s++) begin
            cd = 4'(s);
            n = $countones(chans(cd));
            base = 12'($random(seed));
            nstrb = 0;
            apb(1'b1, 12'h000, ctl(1'b0, 1'b0, cd, 2'h0, 2'h0, 2'h2, 1'b0));
            wait_strobes(2 * n);
            apb(1'b0, 12'h000, 32'h0);
            chk("pen and busy", 32'h2, 32'(rd[15:14]));
            pen_down <= 1'b0;
            run_wait(2000);
            chk_rng("stop on lift", 0, n * (conv(2'h0, 2'h2) + 4) + 8, m);
            chk_res(chans(cd));
            pen_down <= 1'b1;
        end
        nstrb = 0;
        apb(1'b1, 12'h000, ctl(1'b0, 1'b0, 4'h9, 2'h1, 2'h0, 2'h0, 1'b0));
        wait_strobes(3);
        chk_rng("aux repeats", 3, 3, nstrb);
        apb(1'b1, 12'h000, ctl(1'b0, 1'b1, 4'h9, 2'h1, 2'h0, 2'h0, 1'b0));
        chk("halt stops at once", 32'h0, 32'(act));
        chk("halt powers down", 32'h0, 32'(pwr));
        apb(1'b0, 12'h000, 32'h0);
        chk("halted ctrl", 32'h0000c000, rd & 32'hfc00);
        apb(1'b1, 12'h000, 32'h0);
        chk("normal mode", 32'h1, 32'(pwr));
        end_of_test();
    end
endmodule

// >>> dv/touch_panel_model.sv
// Behavioural panel and converter front end facing the control block
module touch_panel_model (
    // Clock
    input  wire logic        clock,
    // Control block side
    input  wire logic        conv_active,
    input  wire logic [3:0]  conv_channel,
    input  wire logic        converter_powered,
    // Bench side; sample out to the control block
    input  wire logic [11:0] base,
    output logic [11:0]      adc_sample
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] level_q = 12'h5a5;
    assign adc_sample = level_q;
    // each channel level holds steady for a whole conversion
    // Off or idle the output toggles so a stale capture cannot pass as a result
    always @(posedge clock) begin
        if (conv_active === 1'b1 && converter_powered === 1'b1)
            level_q <= base ^ {conv_channel, conv_channel, conv_channel};
        else
            level_q <= ~level_q;
    end
endmodule

// >>> rtl/touch_conv_ctrl.sv
// Touch-panel converter control register, sequencer, filters and APB slave
`include "touch_conv_params.svh"
module touch_conv_ctrl #(
    parameter int MAX_SAMPLES = 16
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        nrst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Panel and analogue side
    input  wire logic        pen_down,
    input  wire logic [11:0] adc_sample,
    output logic             x_drivers_on,
    output logic             y_drivers_on,
    output logic             conv_active,
    output logic [3:0]       conv_channel,
    output logic             converter_powered,
    output logic             result_strobe
);
    logic [15:0] ctrl_q;
    logic [11:0] res_q [9];
    logic        pen_m_q, pen_s_q;
    logic [11:0] smp_m_q, smp_s_q;
    touch_conv_pkg::ctl_state_e st_q;
    logic [3:0]  chan_q, first_q;
    logic [7:0]  tick_q, clk_div_q;
    logic [4:0]  bits_left_q;
    logic [4:0]  cnt_q;
    logic [11:0] buf_q [MAX_SAMPLES];
    logic        wr_ctrl, stop_req, seq_ok;
    logic [3:0]  sel;
    logic [4:0]  nsamp;
    logic [11:0] filt_val;

    // Number of system clocks per conversion clock period
    function automatic logic [7:0] clk_div(input logic [1:0] f);
        clk_div = 8'((`TC_SYS_CLK_MHZ * (1 << f) + `TC_CONV_MHZ_MAX - 1) / `TC_CONV_MHZ_MAX);
    endfunction
    function automatic logic [4:0] res_bits(input logic [1:0] r);
        case (r)
            2'h1:    res_bits = 5'h08;
            2'h2:    res_bits = 5'h0a;
            default: res_bits = 5'h0c;
        endcase
    endfunction
    function automatic logic [4:0] samples(input logic [1:0] a, input logic med);
        case (a)
            2'h1:    samples = med ? 5'h05 : 5'h04;
            2'h2:    samples = med ? 5'h09 : 5'h08;
            2'h3:    samples = med ? 5'h0f : 5'h10;
            default: samples = 5'h01;
        endcase
    endfunction
    // First channel of a sequence, or none for codes without conversion
    function automatic logic [3:0] first_ch(input logic [3:0] s);
        case (s)
            4'h1, 4'h2, 4'h3: first_ch = touch_conv_pkg::CH_X;
            4'h4:             first_ch = touch_conv_pkg::CH_Y;
            4'h5:             first_ch = touch_conv_pkg::CH_Z1;
            4'h6, 4'hb:       first_ch = touch_conv_pkg::CH_BATTERY_INPUT_ONE;
            4'h7:             first_ch = touch_conv_pkg::CH_BATTERY_INPUT_TWO;
            4'h8, 4'h9:       first_ch = touch_conv_pkg::CH_AUX;
            4'ha:             first_ch = touch_conv_pkg::CH_T1;
            4'hc:             first_ch = touch_conv_pkg::CH_T2;
            default:          first_ch = 4'hf;
        endcase
    endfunction

    assign sel     = ctrl_q[`TC_SEL_HI:`TC_SEL_LO];
    assign nsamp   = samples(ctrl_q[`TC_AVG_HI:`TC_AVG_LO], ctrl_q[`TC_FILT_BIT]);
    assign wr_ctrl = psel && penable && pwrite && paddr == `TC_CTRL_OFFSET;
    assign stop_req = wr_ctrl && pwdata[`TC_HALT_BIT];
    // device sequencing waits for touch on panel codes
    assign seq_ok = !ctrl_q[`TC_PEN_BIT] || pen_s_q || sel > 4'h5;

    // Pen and sample come from the analogue domain
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pen_m_q <= 1'b0;
            pen_s_q <= 1'b0;
            smp_m_q <= 12'h000;
            smp_s_q <= 12'h000;
        end else begin
            pen_m_q <= pen_down;
            pen_s_q <= pen_m_q;
            smp_m_q <= adc_sample;
            smp_s_q <= smp_m_q;
        end
    end

    // Control register; a stop also clears the select code
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `TC_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= pwdata[15:0];
            if (pwdata[`TC_HALT_BIT]) begin
                ctrl_q[`TC_SEL_HI:`TC_SEL_LO] <= 4'h0;
            end
        end else if (st_q == touch_conv_pkg::ST_NEXT && (chan_q == 4'hf
                     || (chan_q == 4'he && sel != 4'h9 && !pen_s_q))) begin
            ctrl_q[`TC_SEL_HI:`TC_SEL_LO] <= 4'h0;
        end
    end

    // mean or median of the samples
    always_comb begin
        logic [15:0] sum;
        logic [4:0]  below;
        sum = 16'h0000;
        below = 5'h00;
        filt_val = buf_q[0];
        for (int i = 0; i < MAX_SAMPLES; i++) begin
            if (5'(i) < nsamp) begin
                sum = sum + 16'(buf_q[i]);
            end
        end
        if (!ctrl_q[`TC_FILT_BIT]) begin
            case (nsamp)
                5'h04:   filt_val = sum[13:2];
                5'h08:   filt_val = sum[14:3];
                5'h10:   filt_val = sum[15:4];
                default: filt_val = sum[11:0];
            endcase
        end else begin
            for (int i = 0; i < MAX_SAMPLES; i++) begin
                below = 5'h00;
                for (int j = 0; j < MAX_SAMPLES; j++) begin
                    if (5'(j) < nsamp && (buf_q[j] < buf_q[i] || (buf_q[j] == buf_q[i] && j < i))) begin
                        below = below + 5'h01;
                    end
                end
                if (5'(i) < nsamp && below == (nsamp >> 1)) begin
                    filt_val = buf_q[i];
                end
            end
        end
    end

    // Sequencer
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_q        <= touch_conv_pkg::ST_IDLE;
            chan_q      <= 4'h0;
            first_q     <= 4'h0;
            tick_q      <= 8'h00;
            clk_div_q   <= 8'h01;
            bits_left_q <= 5'h00;
            cnt_q       <= 5'h00;
        end else if (stop_req) begin
            st_q <= touch_conv_pkg::ST_IDLE;
        end else begin
            case (st_q)
                touch_conv_pkg::ST_IDLE: begin
                    // code 1110 and driver codes start nothing
                    if (first_ch(sel) != 4'hf && !ctrl_q[`TC_HALT_BIT] && seq_ok) begin
                        chan_q      <= first_ch(sel);
                        first_q     <= first_ch(sel);
                        cnt_q       <= 5'h00;
                        tick_q      <= 8'h00;
                        clk_div_q   <= clk_div(ctrl_q[`TC_CLK_HI:`TC_CLK_LO]);
                        bits_left_q <= res_bits(ctrl_q[`TC_RES_HI:`TC_RES_LO]) + 5'h04;
                        st_q        <= touch_conv_pkg::ST_CONV;
                    end
                end
                touch_conv_pkg::ST_CONV: begin
                    if (tick_q == clk_div_q - 8'h01) begin
                        tick_q <= 8'h00;
                        if (bits_left_q == 5'h01) begin
                            cnt_q <= cnt_q + 5'h01;
                            if (cnt_q + 5'h01 >= nsamp) begin
                                st_q <= touch_conv_pkg::ST_FILT;
                            end else begin
                                bits_left_q <= res_bits(ctrl_q[`TC_RES_HI:`TC_RES_LO]) + 5'h04;
                            end
                        end else begin
                            bits_left_q <= bits_left_q - 5'h01;
                        end
                    end else begin
                        tick_q <= tick_q + 8'h01;
                    end
                end
                touch_conv_pkg::ST_FILT: begin
                    st_q <= touch_conv_pkg::ST_NEXT;
                    case (sel)
                        4'h1: chan_q <= chan_q == 4'h0 ? 4'h1 : 4'he;
                        4'h2: chan_q <= chan_q == 4'h3 ? 4'he : chan_q + 4'h1;
                        4'h5: chan_q <= chan_q == 4'h2 ? 4'h3 : 4'hf;
                        4'hb: chan_q <= chan_q == 4'h4 ? 4'h5 : (chan_q == 4'h5 ? 4'h6 : 4'hf);
                        4'h9: chan_q <= 4'he;
                        default: chan_q <= 4'hf;
                    endcase
                end
                touch_conv_pkg::ST_NEXT: begin
                    cnt_q       <= 5'h00;
                    bits_left_q <= res_bits(ctrl_q[`TC_RES_HI:`TC_RES_LO]) + 5'h04;
                    st_q        <= touch_conv_pkg::ST_CONV;
                    if (chan_q == 4'hf) begin
                        st_q <= touch_conv_pkg::ST_IDLE;
                    end else if (chan_q == 4'he) begin
                        chan_q <= first_q;
                        if (sel != 4'h9 && !pen_s_q) begin
                            st_q <= touch_conv_pkg::ST_IDLE;
                        end
                    end
                end
                default: st_q <= touch_conv_pkg::ST_IDLE;
            endcase
        end
    end

    // Sample capture and result words
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < MAX_SAMPLES; i++) begin
                buf_q[i] <= 12'h000;
            end
            for (int i = 0; i < 9; i++) begin
                res_q[i] <= 12'h000;
            end
        end else begin
            if (st_q == touch_conv_pkg::ST_CONV && tick_q == clk_div_q - 8'h01
                && bits_left_q == 5'h01) begin
                case (ctrl_q[`TC_RES_HI:`TC_RES_LO])
                    2'h1:    buf_q[cnt_q[3:0]] <= {4'h0, smp_s_q[11:4]};
                    2'h2:    buf_q[cnt_q[3:0]] <= {2'h0, smp_s_q[11:2]};
                    default: buf_q[cnt_q[3:0]] <= smp_s_q;
                endcase
            end
            if (st_q == touch_conv_pkg::ST_FILT) begin
                res_q[chan_q] <= filt_val;
            end
        end
    end

    // drivers follow select code when not halted
    assign x_drivers_on      = sel == 4'hd && !ctrl_q[`TC_HALT_BIT];
    assign y_drivers_on      = sel == 4'hf && !ctrl_q[`TC_HALT_BIT];
    assign conv_active       = st_q != touch_conv_pkg::ST_IDLE;
    assign conv_channel      = chan_q;
    assign converter_powered = !ctrl_q[`TC_HALT_BIT];
    assign result_strobe     = st_q == touch_conv_pkg::ST_FILT;

    // APB: zero wait states, unmapped reads zero with error
    assign pready = 1'b1;
    always_comb begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        if (paddr == `TC_CTRL_OFFSET) begin
            prdata[15:0] = ctrl_q;
            prdata[`TC_PEN_BIT]  = pen_s_q;
            prdata[`TC_HALT_BIT] = st_q == touch_conv_pkg::ST_IDLE;
        end else if (paddr == `TC_SAMPLE_OFFSET) begin
            prdata[11:0] = smp_s_q;
        end else if (paddr >= `TC_RES_X_OFFSET && paddr < `TC_RES_X_OFFSET + 12'h024
                     && paddr[1:0] == 2'h0) begin
            prdata[11:0] = res_q[4'(paddr[5:2] - 4'h4)];
        end else begin
            pslverr = psel && penable;
        end
    end

    chk_busy_read: assert property (@(posedge clock) disable iff (!nrst)
        paddr == `TC_CTRL_OFFSET |-> prdata[`TC_HALT_BIT] == !conv_active)
        else $error("busy state inconsistent");
    chk_halt_stop: assert property (@(posedge clock) disable iff (!nrst)
        stop_req |=> st_q == touch_conv_pkg::ST_IDLE && !converter_powered)
        else $error("halt did not stop conversion");
    chk_rsvd_idle: assert property (@(posedge clock) disable iff (!nrst)
        sel == 4'he |-> !x_drivers_on && !y_drivers_on)
        else $error("drivers on for reserved code");
    chk_drv_excl: assert property (@(posedge clock) disable iff (!nrst)
        !(x_drivers_on && y_drivers_on))
        else $error("both drivers on");
    chk_clk_readback: assert property (@(posedge clock) disable iff (!nrst)
        wr_ctrl |=> ctrl_q[5:4] == $past(pwdata[5:4]))
        else $error("clock field readback wrong");
    chk_conv_len: assert property (@(posedge clock) disable iff (!nrst)
        $rose(conv_active) |-> bits_left_q == res_bits($past(ctrl_q[9:8])) + 5'h04)
        else $error("conversion length wrong");
    chk_pen_read: assert property (@(posedge clock) disable iff (!nrst)
        paddr == `TC_CTRL_OFFSET |-> prdata[15] == pen_s_q)
        else $error("pen bit readback wrong");
    chk_single_end: assert property (@(posedge clock) disable iff (!nrst)
        st_q == touch_conv_pkg::ST_FILT && (sel == 4'h3 || sel == 4'h4) && !stop_req
        |=> chan_q == 4'hf)
        else $error("single conversion did not end");
    chk_scan_stop: assert property (@(posedge clock) disable iff (!nrst)
        st_q == touch_conv_pkg::ST_NEXT && chan_q == 4'he && sel != 4'h9 && !pen_s_q
        && !wr_ctrl |=> !conv_active && sel == 4'h0)
        else $error("scan kept running after pen lift");
    chk_aux_repeat: assert property (@(posedge clock) disable iff (!nrst)
        st_q == touch_conv_pkg::ST_NEXT && sel == 4'h9 && chan_q == 4'he && !stop_req
        |=> st_q == touch_conv_pkg::ST_CONV)
        else $error("auxiliary scan did not repeat");
    chk_port_walk: assert property (@(posedge clock) disable iff (!nrst)
        st_q == touch_conv_pkg::ST_FILT && sel == 4'hb && chan_q == 4'h4 && !stop_req
        |=> chan_q == 4'h5)
        else $error("port scan skipped a channel");
    chk_z_pair: assert property (@(posedge clock) disable iff (!nrst)
        st_q == touch_conv_pkg::ST_FILT && sel == 4'h5 && chan_q == 4'h3 && !stop_req
        |=> chan_q == 4'hf)
        else $error("pressure pair did not end");
    chk_halt_idle: assert property (@(posedge clock) disable iff (!nrst)
        ctrl_q[`TC_HALT_BIT] && !conv_active |=> !conv_active)
        else $error("conversion started while halted");
    chk_pen_wait: assert property (@(posedge clock) disable iff (!nrst)
        ctrl_q[`TC_PEN_BIT] && !conv_active && sel <= 4'h5 && !pen_s_q |=> !conv_active)
        else $error("panel conversion started without touch");
    chk_strobe_pulse: assert property (@(posedge clock) disable iff (!nrst)
        result_strobe |=> !result_strobe)
        else $error("result strobe longer than one cycle");
    chk_clock_div: assert property (@(posedge clock) disable iff (!nrst)
        $rose(conv_active) |-> clk_div_q == clk_div($past(ctrl_q[`TC_CLK_HI:`TC_CLK_LO])))
        else $error("conversion clock divider wrong");
    chk_rsvd_nostart: assert property (@(posedge clock) disable iff (!nrst)
        sel == 4'he && !conv_active |=> !conv_active)
        else $error("reserved code started a conversion");
endmodule

// >>> rtl/touch_conv_params.svh
// Register offsets, field positions, reset values and clock rates of the converter control
`ifndef TOUCH_CONV_PARAMS_SVH
`define TOUCH_CONV_PARAMS_SVH
`define TC_CTRL_OFFSET   12'h000
`define TC_SAMPLE_OFFSET 12'h004
`define TC_RES_X_OFFSET  12'h010
`define TC_PEN_BIT       15
`define TC_HALT_BIT      14
`define TC_SEL_HI        13
`define TC_SEL_LO        10
`define TC_RES_HI        9
`define TC_RES_LO        8
`define TC_AVG_HI        7
`define TC_AVG_LO        6
`define TC_CLK_HI        5
`define TC_CLK_LO        4
`define TC_FILT_BIT      0
`define TC_CTRL_RESET    16'h0000
`define TC_SYS_CLK_MHZ   50
`define TC_CONV_MHZ_MAX  8
`endif

// >>> rtl/touch_conv_pkg.sv
// Types shared by the converter control design
package touch_conv_pkg;
    typedef enum logic [3:0] {
        SEL_NONE  = 4'h0, SEL_XY    = 4'h1, SEL_XYZ  = 4'h2, SEL_X     = 4'h3,
        SEL_Y     = 4'h4, SEL_Z     = 4'h5, SEL_BATTERY_INPUT_ONE = 4'h6, SEL_BATTERY_INPUT_TWO  = 4'h7,
        SEL_AUX   = 4'h8, SEL_AUXSC = 4'h9, SEL_T1   = 4'ha, SEL_PORT  = 4'hb,
        SEL_T2    = 4'hc, SEL_DRVX  = 4'hd, SEL_RSVD = 4'he, SEL_DRVY  = 4'hf
    } conv_sel_e;
    // Destination index of a result; each has its own result word
    typedef enum logic [3:0] {
        CH_X = 4'h0, CH_Y = 4'h1, CH_Z1 = 4'h2, CH_Z2 = 4'h3, CH_BATTERY_INPUT_ONE = 4'h4,
        CH_BATTERY_INPUT_TWO = 4'h5, CH_AUX = 4'h6, CH_T1 = 4'h7, CH_T2 = 4'h8
    } chan_e;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001, ST_CONV = 4'b0010, ST_FILT = 4'b0100, ST_NEXT = 4'b1000
    } ctl_state_e;
endpackage
